/* shared/pmf_defs.vh */
// constants for the power mode and output format configuration register
`ifndef PMF_DEFS_VH
`define PMF_DEFS_VH
// ==========================================
// register offsets
`define PMF_ADDR_CTRL        8'h16
`define PMF_ADDR_RATE        8'h17
`define PMF_ADDR_TEMP        8'h01
`define PMF_ADDR_OUT_FIRST   8'h04
`define PMF_ADDR_OUT_LAST    8'h09
`define PMF_ADDR_BUF_FIRST   8'h18
`define PMF_ADDR_BUF_LAST    8'h1D
// ==========================================
// reset values
`define PMF_CTRL_RESET       8'h00
`define PMF_RATE_RESET       8'h00
// ==========================================
// field positions
`define PMF_WAKE_POWER_SELECT_HI       7
`define PMF_WAKE_POWER_SELECT_LO       6
`define PMF_SLEEP_POWER_SELECT_HI      5
`define PMF_SLEEP_POWER_SELECT_LO      4
`define PMF_BYTE_ORDER_BIT   3
`define PMF_SPARE_BIT        2
`define PMF_TEMP_AINC_BIT    1
`define PMF_FAST_READ_BIT    0
// ==========================================
// power mode encodings
`define PMF_PM_LOW           2'h0
`define PMF_PM_HIGH          2'h1
`define PMF_MODE_LP          2'h0
`define PMF_MODE_HP          2'h1
`define PMF_MODE_FLEX        2'h2
// ==========================================
// flexible mode base period
`define PMF_BASE_PERIOD_NS   312500
`define PMF_CLK_PERIOD_NS    10
`define PMF_BASE_CYCLES      (`PMF_BASE_PERIOD_NS / `PMF_CLK_PERIOD_NS)
// last count of one base period, sized for the base divider
`define PMF_BASE_LAST        16'h7A11
`endif

/* rtl/pmf_config.v */
// power mode and output format configuration register with its effects
`timescale 1ns/1ns
`include "pmf_defs.vh"

// Functional notes
// - wake 00b selects low-power, upper nibble rate
// - wake 01b selects high-performance, upper nibble code
// - wake 1xb flexible, upper nibble is decimation
// - sleep 00b selects low-power, lower nibble rate
// - sleep 01b selects high-performance, lower nibble code
// - sleep 1xb flexible, lower nibble is decimation
// - byte order clear gives little-endian, right-justified
// - byte order set gives big-endian, left-justified
// - byte order only on axis, magnitude, buffer
// - temperature bit adds temp to auto-increment
// - fast read returns only sample MSB
// - fast read MSB at lower address always
// - fast read burst skips each axis upper address
// - flexible rate from idle, base period, decimation
module pmf_config (
  input  wire        clk,
  input  wire        rst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        in_wake,
  input  wire [11:0] wake_idle,
  input  wire [11:0] sleep_idle,
  input  wire [11:0] sample_data,
  input  wire        sample_is_formatted,
  input  wire        burst_step,
  output reg  [7:0]  reg_rdata,
  output reg  [1:0]  wake_mode,
  output reg  [1:0]  sleep_mode,
  output reg  [3:0]  wake_rate_code,
  output reg  [3:0]  sleep_rate_code,
  output reg  [3:0]  wake_decimation,
  output reg  [3:0]  sleep_decimation,
  output reg  [1:0]  active_mode,
  output reg  [7:0]  fmt_low_byte,
  output reg  [7:0]  fmt_high_byte,
  output reg  [7:0]  next_ptr,
  output reg         rate_tick
);

  // ==========================================
  // register storage
  reg  [7:0]  power_mode_format_ctrl;
  reg  [7:0]  rate_config_reg;
  wire [1:0]  wake_power_select;
  wire [1:0]  sleep_power_select;
  wire        output_byte_order;
  wire        temp_in_autoinc;
  wire        fast_read;
  reg  [7:0]  ptr;

  assign wake_power_select  = power_mode_format_ctrl[`PMF_WAKE_POWER_SELECT_HI:`PMF_WAKE_POWER_SELECT_LO];
  assign sleep_power_select = power_mode_format_ctrl[`PMF_SLEEP_POWER_SELECT_HI:`PMF_SLEEP_POWER_SELECT_LO];
  assign output_byte_order  = power_mode_format_ctrl[`PMF_BYTE_ORDER_BIT];
  assign temp_in_autoinc    = power_mode_format_ctrl[`PMF_TEMP_AINC_BIT];
  assign fast_read          = power_mode_format_ctrl[`PMF_FAST_READ_BIT];

  // register writes; all eight bits stored as written
  // spare bit stored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      power_mode_format_ctrl <= `PMF_CTRL_RESET;
      rate_config_reg        <= `PMF_RATE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `PMF_ADDR_CTRL)
        power_mode_format_ctrl <= reg_wdata;
      if (reg_addr == `PMF_ADDR_RATE)
        rate_config_reg <= reg_wdata;
    end
  end

  // register reads; unmapped addresses read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PMF_ADDR_CTRL: reg_rdata <= power_mode_format_ctrl;
        `PMF_ADDR_RATE: reg_rdata <= rate_config_reg;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // power mode decode and rate nibble interpretation
  wire [1:0] next_wake_mode;
  wire [1:0] next_sleep_mode;
  wire [3:0] next_wake_rate;
  wire [3:0] next_sleep_rate;
  wire [3:0] next_wake_decimation;
  wire [3:0] next_sleep_decimation;

  pmf_pm_decode u_wake_decode (
    .power_select (wake_power_select),
    .rate_nibble  (rate_config_reg[7:4]),
    .mode         (next_wake_mode),
    .rate_code    (next_wake_rate),
    .decimation   (next_wake_decimation)
  );

  pmf_pm_decode u_sleep_decode (
    .power_select (sleep_power_select),
    .rate_nibble  (rate_config_reg[3:0]),
    .mode         (next_sleep_mode),
    .rate_code    (next_sleep_rate),
    .decimation   (next_sleep_decimation)
  );

  // registered mode outputs; active mode follows the wake or sleep state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_mode        <= `PMF_MODE_LP;
      sleep_mode       <= `PMF_MODE_LP;
      wake_rate_code   <= 4'h0;
      sleep_rate_code  <= 4'h0;
      wake_decimation  <= 4'h0;
      sleep_decimation <= 4'h0;
      active_mode      <= `PMF_MODE_LP;
    end else begin
      wake_mode        <= next_wake_mode;
      sleep_mode       <= next_sleep_mode;
      wake_rate_code   <= next_wake_rate;
      sleep_rate_code  <= next_sleep_rate;
      wake_decimation  <= next_wake_decimation;
      sleep_decimation <= next_sleep_decimation;
      active_mode      <= in_wake ? next_wake_mode : next_sleep_mode;
    end
  end

  // ==========================================
  // flexible mode sample timer: (idle+1) base periods times 2^dec
  wire [11:0] cur_idle;
  wire [3:0]  cur_dec;
  wire [15:0] dec_limit;
  wire        flex_now;
  wire        base_tick;
  wire        idle_wrap;
  wire        dec_wrap;

  assign flex_now  = (active_mode == `PMF_MODE_FLEX);
  assign cur_idle  = in_wake ? wake_idle : sleep_idle;
  assign cur_dec   = in_wake ? wake_decimation : sleep_decimation;
  assign dec_limit = (16'h0001 << cur_dec) - 16'h0001;

  pmf_step_div #(
    .WIDTH (16)
  ) u_base_div (
    .clk   (clk),
    .rst   (rst),
    .clr   (!flex_now),
    .step  (flex_now),
    .limit (`PMF_BASE_LAST),
    .wrap  (base_tick)
  );

  pmf_step_div #(
    .WIDTH (12)
  ) u_idle_div (
    .clk   (clk),
    .rst   (rst),
    .clr   (!flex_now),
    .step  (base_tick),
    .limit (cur_idle),
    .wrap  (idle_wrap)
  );

  pmf_step_div #(
    .WIDTH (16)
  ) u_dec_div (
    .clk   (clk),
    .rst   (rst),
    .clr   (!flex_now),
    .step  (idle_wrap),
    .limit (dec_limit),
    .wrap  (dec_wrap)
  );

  // one-cycle sample pulse at the end of each flexible period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= dec_wrap;
    end
  end

  // ==========================================
  // output sample formatting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt_low_byte  <= 8'h00;
      fmt_high_byte <= 8'h00;
    end else if (fast_read) begin
      fmt_low_byte  <= sample_data[11:4];
      fmt_high_byte <= 8'h00;
    end else if (output_byte_order && sample_is_formatted) begin
      fmt_low_byte  <= sample_data[11:4];
      fmt_high_byte <= {sample_data[3:0], 4'h0};
    end else begin
      fmt_low_byte  <= sample_data[7:0];
      fmt_high_byte <= {4'h0, sample_data[11:8]};
    end
  end

  // ==========================================
  // burst read address pointer
  wire in_out_range;
  wire in_buf_range;
  reg  [7:0] next_addr;

  assign in_out_range = (ptr >= `PMF_ADDR_OUT_FIRST) && (ptr <= `PMF_ADDR_OUT_LAST);
  assign in_buf_range = (ptr >= `PMF_ADDR_BUF_FIRST) && (ptr <= `PMF_ADDR_BUF_LAST);

  always @* begin
    next_addr = ptr + 8'h01;
    if (fast_read && (in_out_range || in_buf_range))
      next_addr = ptr + 8'h02;
    if (!temp_in_autoinc && next_addr == `PMF_ADDR_TEMP)
      next_addr = next_addr + 8'h01;
  end

  // pointer loads on a register access and steps on each burst byte
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr      <= 8'h00;
      next_ptr <= 8'h00;
    end else if (reg_rd || reg_wr) begin
      ptr      <= reg_addr;
      next_ptr <= reg_addr;
    end else if (burst_step) begin
      ptr      <= next_addr;
      next_ptr <= next_addr;
    end
  end

endmodule

// ==========================================
// power select decode shared by the wake and sleep halves
module pmf_pm_decode (
  input  wire [1:0] power_select,
  input  wire [3:0] rate_nibble,
  output reg  [1:0] mode,
  output reg  [3:0] rate_code,
  output reg  [3:0] decimation
);

  // nibble is a rate code outside flexible mode, a decimation code inside
  always @* begin
    mode       = `PMF_MODE_LP;
    rate_code  = rate_nibble;
    decimation = 4'h0;
    if (power_select[1]) begin
      mode       = `PMF_MODE_FLEX;
      rate_code  = 4'h0;
      decimation = rate_nibble;
    end else if (power_select == `PMF_PM_HIGH) begin
      mode = `PMF_MODE_HP;
    end
  end

endmodule

// ==========================================
// step counter that wraps once the count reaches its limit
module pmf_step_div #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             clr,
  input  wire             step,
  input  wire [WIDTH-1:0] limit,
  output wire             wrap
);

  reg [WIDTH-1:0] cnt;

  // at-or-past compare, so a lowered limit never strands the count
  assign wrap = step && (cnt >= limit);

  // counts steps; held at zero while cleared
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= {WIDTH{1'h0}};
    end else if (clr || wrap) begin
      cnt <= {WIDTH{1'h0}};
    end else if (step) begin
      cnt <= cnt + {{(WIDTH-1){1'h0}}, 1'h1};
    end
  end

endmodule

/* tb/pmf_config_monitor.sv */
// checker for the power mode and format register
`timescale 1ns/1ns
module pmf_config_monitor (
  input wire        clk,
  input wire        rst,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        in_wake,
  input wire [11:0] wake_idle,
  input wire [11:0] sleep_idle,
  input wire [11:0] sample_data,
  input wire        sample_is_formatted,
  input wire        burst_step,
  input wire [7:0]  reg_rdata,
  input wire [1:0]  wake_mode,
  input wire [1:0]  sleep_mode,
  input wire [3:0]  wake_rate_code,
  input wire [3:0]  sleep_rate_code,
  input wire [3:0]  wake_decimation,
  input wire [3:0]  sleep_decimation,
  input wire [1:0]  active_mode,
  input wire [7:0]  fmt_low_byte,
  input wire [7:0]  fmt_high_byte,
  input wire [7:0]  next_ptr,
  input wire        rate_tick
);
  logic [7:0]  sh;
  logic [7:0]  sd;
  logic [11:0] sp;
  function automatic logic [1:0] md(input logic [1:0] x);
    md = x[1] ? 2'h2 : x;
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] p, input logic [7:0] m);
    nx = p + ((m[0] && (p inside {[8'h04:8'h09], [8'h18:8'h1D]})) ? 8'h02 : 8'h01);
    if (nx == 8'h01 && !m[1]) nx = 8'h02;
  endfunction
  // shadow of the control register, its delayed copy and the last sample
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sh <= 8'h00;
      sd <= 8'h00;
      sp <= 12'h000;
    end else begin
      if (reg_wr && reg_addr == 8'h16) sh <= reg_wdata;
      sd <= sh;
      sp <= sample_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_wake_mode_map: assert property (reg_wr && reg_addr == 8'h16 |-> ##2 wake_mode == md(sd[7:6]))
    else $error("wake mode decode");
  a_sleep_mode_map: assert property (reg_wr && reg_addr == 8'h16 |-> ##2 sleep_mode == md(sd[5:4]))
    else $error("sleep mode decode");
  a_flex_nibble_use: assert property ((wake_mode == 2'h2 ? wake_rate_code : wake_decimation) == 4'h0 && (sleep_mode == 2'h2 ? sleep_rate_code : sleep_decimation) == 4'h0)
    else $error("nibble routing");
  a_ctrl_read_back: assert property (reg_rd && !reg_wr && reg_addr == 8'h16 |=> reg_rdata == sh)
    else $error("read back");
  a_fast_read_msb: assert property ($stable(sh) && sh[0] |=> fmt_low_byte == sp[11:4] && fmt_high_byte == 8'h00)
    else $error("fast read bytes");
  a_big_endian_fmt: assert property ($stable(sh) && !sh[0] && sh[3] && sample_is_formatted |=> {fmt_low_byte, fmt_high_byte} == {sp, 4'h0})
    else $error("big endian bytes");
  a_little_endian_fmt: assert property ($stable(sh) && !sh[0] && !(sh[3] && sample_is_formatted) |=> {fmt_low_byte, fmt_high_byte} == {sp[7:0], 4'h0, sp[11:8]})
    else $error("little endian bytes");
  a_burst_ptr_step: assert property (burst_step && !reg_wr && !reg_rd && $stable(sh) |=> next_ptr == nx($past(next_ptr), $past(sh)))
    else $error("burst pointer step");
  c_flex_tick: cover property (rate_tick);
  c_fast_burst: cover property (burst_step && sh[0]);
  c_wake_flex: cover property (wake_mode == 2'h2 && in_wake);
endmodule
bind pmf_config pmf_config_monitor u_mon (.*);

/* tb/pmf_config_tb.sv */
// self-checking bench for the power mode and format register
`timescale 1ns/1ns
module pmf_config_tb;
  logic        clk, rst, reg_wr, reg_rd, in_wake, sample_is_formatted, burst_step, rate_tick;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, fmt_low_byte, fmt_high_byte, next_ptr, c, r;
  logic [11:0] wake_idle, sleep_idle, sample_data;
  logic [1:0]  wake_mode, sleep_mode, active_mode;
  logic [3:0]  wake_rate_code, sleep_rate_code, wake_decimation, sleep_decimation;
  logic [23:0] pt [8];
  int          n_fail, tests_run, cyc, k;
  pmf_config DUT (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      n_fail++;
      results;
    end
  end
  function automatic logic [1:0] md(input logic [1:0] x);
    md = x[1] ? 2'h2 : x;
  endfunction
  function automatic logic [15:0] fm(input logic [7:0] m, input logic [11:0] s, input logic f);
    if (m[0]) fm = {s[11:4], 8'h00};
    else if (m[3] && f) fm = {s, 4'h0};
    else fm = {s[7:0], 4'h0, s[11:8]};
  endfunction
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    tick;
  endtask
  task wait_tick;
    k = 0;
    do begin
      tick;
      k++;
    end while (!rate_tick && k < 40000);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    k = $urandom(31);
    {rst, reg_wr, reg_rd, in_wake, sample_is_formatted, burst_step} = 6'h20;
    {reg_addr, reg_wdata, wake_idle, sample_data} = '0;
    sleep_idle = $urandom;
    pt = '{24'h000002, 24'h000201, 24'h040106, 24'h09010B, 24'h09000A, 24'h1D011F, 24'h1E011F, 24'h170118};
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    // random read back, then an ignored write to an unmapped place
    repeat (8) begin
      c = $urandom;
      wr(8'h16, c);
      rd(8'h16, c);
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(8'h16, c);
    // every power select pair with random rate nibbles
    for (int i = 0; i < 16; i++) begin
      c = {i[3:0], 4'($urandom)};
      r = $urandom;
      in_wake = $urandom;
      wr(8'h16, c);
      wr(8'h17, r);
      chk(wake_mode, md(c[7:6]));
      chk(sleep_mode, md(c[5:4]));
      chk({wake_rate_code, wake_decimation}, c[7] ? {4'h0, r[7:4]} : {r[7:4], 4'h0});
      chk({sleep_rate_code, sleep_decimation}, c[5] ? {4'h0, r[3:0]} : {r[3:0], 4'h0});
      chk(active_mode, in_wake ? md(c[7:6]) : md(c[5:4]));
    end
    // byte order, fast read and formatted flag in all combinations
    for (int i = 0; i < 16; i++) begin
      c = {4'h0, i[1], i[2], 1'b0, i[0]};
      wr(8'h16, c);
      sample_data = $urandom;
      sample_is_formatted = i[3];
      tick;
      chk({fmt_low_byte, fmt_high_byte}, fm(c, sample_data, i[3]));
    end
    // burst pointer corner cases
    foreach (pt[j]) begin
      wr(8'h16, pt[j][15:8]);
      reg_addr = pt[j][23:16];
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      burst_step = 1'b1;
      tick;
      burst_step = 1'b0;
      chk(next_ptr, pt[j][7:0]);
    end
    // flexible wake rate with zero idle and decimation code
    wr(8'h16, 8'h80);
    wr(8'h17, 8'h00);
    in_wake = 1'b1;
    wait_tick;
    wait_tick;
    chk(k[15:0], 16'h7A12);
    results;
  end
endmodule
